// [common/twd_defines.svh]
/*
 Constants of the two-wire debug port: register selects, reset values,
 flash command codes, link instruction codes and frame layout.
 Assumes inclusion by the package and by both ends.
*/
`ifndef TWD_DEFINES_SVH
`define TWD_DEFINES_SVH

`define TWD_SEL_DEVICE_IDENTITY     8'h00
`define TWD_SEL_SILICON_REVISION    8'h01
`define TWD_SEL_FLASH_PROG_CONTROL  8'h02
`define TWD_SEL_FLASH_PROG_DATA     8'had
`define TWD_SEL_RESET               8'h00
`define TWD_PROG_CTL_RESET          8'h00
`define TWD_PROG_DAT_RESET          8'h00
`define TWD_UNLOCK_FIRST            8'h02
`define TWD_UNLOCK_SECOND           8'h01
`define TWD_CMD_BLOCK_READ          8'h06
`define TWD_CMD_DEVICE_ERASE        8'h03
`define TWD_UNMAPPED_READ           8'h00

`define TWD_INS_DATA_READ           2'h0
`define TWD_INS_DATA_WRITE          2'h1
`define TWD_INS_ADDR_WRITE          2'h2
`define TWD_INS_ADDR_READ           2'h3

`define TWD_FRAME_BITS              11
`define TWD_LAST_BIT                4'ha
`define TWD_FIRST_DATA_BIT          4'h3
`define TWD_HALF_PERIOD             16
`define TWD_HALF_MIN                12

`define TWD_HREG_DATA               4'h0
`define TWD_HREG_COMMAND            4'h1
`define TWD_HREG_STATUS             4'h2

`endif

// [common/twd_pkg.sv]
/*
 Types of the two-wire debug port: state enums and the state records of
 both ends. Assumes the defines header is on the include path.
*/
package twd_pkg;
`include "twd_defines.svh"

   typedef enum logic [2:0] {DS_IDLE, DS_INSTR, DS_WDATA, DS_RDATA, DS_STOP} twd_dev_state_t;
   typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} twd_host_state_t;

   typedef struct packed {
      logic [2:0]     ck_sync;
      logic [2:0]     dt_sync;
      logic           ck_st;
      logic           dt_st;
      twd_dev_state_t st;
      logic [3:0]     bitn;
      logic [1:0]     ins;
      logic [7:0]     shift;
      logic [7:0]     sel;
      logic [7:0]     prog_ctl;
      logic [7:0]     prog_dat;
      logic           armed;
      logic           enabled;
      logic           cmd_open;
      logic           oe;
      logic           dout;
      logic           user_rst_n;
      logic           user_data;
      logic           cmd_valid;
      logic [7:0]     cmd;
      logic           blk_read;
      logic           dev_erase;
      logic           byte_valid;
      logic [7:0]     fbyte;
   } twd_dev_t;

   typedef struct packed {
      logic [7:0]      div;
      logic            clk;
      logic            oe;
      logic            dout;
      logic [2:0]      dt_sync;
      logic            dt_st;
      twd_host_state_t st;
      logic [3:0]      bitn;
      logic [10:0]     frame;
      logic            rd;
      logic [7:0]      rx;
      logic [7:0]      rxdata;
      logic            rx_valid;
      logic            busy;
      logic [7:0]      tx;
      logic [7:0]      rdata;
   } twd_host_t;
endpackage

// [common/twd_link_if.sv]
/*
 Link between debug host and target: host-driven clock pin, shared data
 pin with a weak pull-up. Assumes at most one end enables its driver.
*/
`timescale 1ns/100ps
interface twd_link_if;
   logic debug_link_clock_pin;
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   logic debug_link_data_pin;

   // Pull-up when nobody drives
   assign debug_link_data_pin = host_data_oe ? host_data_out :
                                dev_data_oe  ? dev_data_out  : 1'b1;

   modport host (output debug_link_clock_pin, output host_data_out, output host_data_oe,
                 input debug_link_data_pin);
   modport device (input debug_link_clock_pin, output dev_data_out, output dev_data_oe,
                   input debug_link_data_pin);
endinterface

// [verilog/twd_target.sv]
/*
 Target end of the two-wire debug port: link receiver, register select,
 identity, revision, flash programming control and data, pin borrowing.
 Assumes halted_in comes from the core on mclk_in; link pins are async.
*/
// The address-and-strobe port was chosen for this implementation.
//
// Summary of operation
// RL1 - One host clock line, one shared data line
// RL2 - Address register selects data read/write target
// RL3 - Select 0x00 reads fixed identity, ignores writes
// RL4 - Select 0x01 reads revision code, read-only
// RL5 - Writing 0x02 then 0x01 enables programming
// RL6 - Programming stays enabled until system reset
// RL7 - Data register carries commands, addresses, data
// RL8 - Decode 0x06 block read, 0x03 erase
// RL9 - Link traffic runs while the core halts
// RL10 - Halted core lends reset and data pins
// RL11 - User data input held steady while halted
// RL12 - Reset pin used only as input
// RL13 - No flash commands before the unlock sequence
//
`timescale 1ns/100ps
`include "twd_defines.svh"
module twd_target
   import twd_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID   = 8'h5a, // Arbitrary identity value
   parameter logic [7:0] REVISION_ID = 8'h00
)(
   input  wire logic   mclk_in,
   input  wire logic   resetn_in,
   twd_link_if.device  link,
   input  wire logic   halted_in,
   input  wire logic   flash_load_in,
   input  wire logic [7:0] flash_load_data_in,
   input  wire logic   flash_done_in,
   output logic        prog_enabled_out,
   output logic        user_rst_n_out,
   output logic        user_data_out,
   output logic        flash_cmd_valid_out,
   output logic [7:0]  flash_cmd_out,
   output logic        flash_block_read_out,
   output logic        flash_device_erase_out,
   output logic        flash_byte_valid_out,
   output logic [7:0]  flash_byte_out
);

////////////////////////////////////////////////////////////////////////////////

   twd_dev_t q;
   twd_dev_t d;

   function automatic logic [7:0] read_sel(input twd_dev_t s);
      logic [7:0] v;
      v = `TWD_UNMAPPED_READ;
      if (s.sel == `TWD_SEL_DEVICE_IDENTITY)
      begin
         v = DEVICE_ID;                                  // see RL3
      end
      else if (s.sel == `TWD_SEL_SILICON_REVISION)
      begin
         v = REVISION_ID;                                // see RL4
      end
      else if (s.sel == `TWD_SEL_FLASH_PROG_CONTROL)
      begin
         v = s.prog_ctl;
      end
      else if (s.sel == `TWD_SEL_FLASH_PROG_DATA)
      begin
         v = s.prog_dat;
      end
      return v;
   endfunction

   function automatic logic is_read(input logic [1:0] ins);
      return (ins == `TWD_INS_DATA_READ) || (ins == `TWD_INS_ADDR_READ);
   endfunction

////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      logic       ck_new;
      logic       dt_new;
      logic       rise;
      logic       fall;
      logic [1:0] ins_new;
      logic [7:0] wb;
      ck_new  = 1'b0;
      dt_new  = 1'b0;
      rise    = 1'b0;
      fall    = 1'b0;
      ins_new = 2'h0;
      wb      = 8'h00;
      d = q;
      d.cmd_valid  = 1'b0;
      d.blk_read   = 1'b0;
      d.dev_erase  = 1'b0;
      d.byte_valid = 1'b0;
      // Pins are async: three stages, change accepted when last two agree
      d.ck_sync = {q.ck_sync[1:0], link.debug_link_clock_pin};
      d.dt_sync = {q.dt_sync[1:0], link.debug_link_data_pin};
      ck_new = (q.ck_sync[1] == q.ck_sync[2]) ? q.ck_sync[2] : q.ck_st;
      dt_new = (q.dt_sync[1] == q.dt_sync[2]) ? q.dt_sync[2] : q.dt_st;
      d.ck_st = ck_new;
      d.dt_st = dt_new;
      rise = ck_new & ~q.ck_st;
      fall = ~ck_new & q.ck_st;
      ins_new = {q.ins[0], dt_new};
      wb = {q.shift[6:0], dt_new};
      // Done first so that a command taken in the same cycle still opens
      if (flash_done_in)
      begin
         d.cmd_open = 1'b0;
      end
      if (!halted_in)
      begin
         // Pins belong to the application while the core runs
         d.st         = DS_IDLE;                         // see RL9
         d.oe         = 1'b0;
         d.user_rst_n = ck_new;                          // see RL12
         d.user_data  = dt_new;
      end
      else
      begin
         // Borrowed: reset held off, user data frozen at last value
         d.user_rst_n = 1'b1;                            // see RL10
         case (q.st)
            DS_IDLE:
            begin
               if (rise && dt_new)
               begin
                  d.st   = DS_INSTR;                     // see RL1
                  d.bitn = 4'h0;
               end
            end
            DS_INSTR:
            begin
               if (rise)
               begin
                  d.ins  = ins_new;
                  d.bitn = q.bitn + 4'h1;
                  if (q.bitn == 4'h1)
                  begin
                     d.bitn = 4'h0;
                     if (is_read(ins_new))
                     begin
                        d.st    = DS_RDATA;
                        d.shift = (ins_new == `TWD_INS_ADDR_READ) ? q.sel : read_sel(q);
                     end
                     else
                     begin
                        d.st = DS_WDATA;
                     end
                  end
               end
            end
            DS_WDATA:
            begin
               if (rise)
               begin
                  d.shift = wb;
                  d.bitn  = q.bitn + 4'h1;
                  if (q.bitn == 4'h7)
                  begin
                     d.st = DS_STOP;
                     if (q.ins == `TWD_INS_ADDR_WRITE)
                     begin
                        d.sel = wb;                      // see RL2
                     end
                     else if (q.sel == `TWD_SEL_FLASH_PROG_CONTROL)
                     begin
                        d.prog_ctl = wb;
                        // Any other byte breaks the sequence
                        d.armed = (wb == `TWD_UNLOCK_FIRST);
                        if (q.armed && wb == `TWD_UNLOCK_SECOND)
                        begin
                           d.enabled = 1'b1;             // see RL5
                        end
                     end
                     else if (q.sel == `TWD_SEL_FLASH_PROG_DATA)
                     begin
                        d.prog_dat = wb;                 // see RL7
                        if (q.enabled && !q.cmd_open)    // see RL13
                        begin
                           d.cmd_open  = 1'b1;
                           d.cmd_valid = 1'b1;
                           d.cmd       = wb;
                           d.blk_read  = (wb == `TWD_CMD_BLOCK_READ);   // see RL8
                           d.dev_erase = (wb == `TWD_CMD_DEVICE_ERASE); // see RL8
                        end
                        else if (q.enabled)
                        begin
                           d.byte_valid = 1'b1;
                           d.fbyte      = wb;
                        end
                     end
                     // Identity and revision writes fall through unused
                  end
               end
            end
            DS_RDATA:
            begin
               if (fall)
               begin
                  d.bitn = q.bitn + 4'h1;
                  if (q.bitn == 4'h8)
                  begin
                     d.oe = 1'b0;
                     d.st = DS_STOP;
                  end
                  else
                  begin
                     d.oe    = 1'b1;
                     d.dout  = q.shift[7];
                     d.shift = {q.shift[6:0], 1'b0};
                  end
               end
            end
            DS_STOP:
            begin
               // Tail rise ends the frame; the pull-up would fake a start
               if (rise)
               begin
                  d.st = DS_IDLE;
               end
            end
            default:
            begin
               d.st = DS_IDLE;
            end
         endcase
      end
      // Flash side reloads the data register for block reads
      if (flash_load_in)
      begin
         d.prog_dat = flash_load_data_in;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         // Only a system reset leaves programming mode
         q <= '0;                                        // see RL6
         // Clock pin idles high: no false rise after reset
         q.ck_sync <= 3'h7;
         q.ck_st   <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign link.dev_data_out      = q.dout;
   assign link.dev_data_oe       = q.oe;
   assign prog_enabled_out       = q.enabled;
   assign user_rst_n_out         = q.user_rst_n;
   assign user_data_out          = q.user_data;          // see RL11
   assign flash_cmd_valid_out    = q.cmd_valid;
   assign flash_cmd_out          = q.cmd;
   assign flash_block_read_out   = q.blk_read;
   assign flash_device_erase_out = q.dev_erase;
   assign flash_byte_valid_out   = q.byte_valid;
   assign flash_byte_out         = q.fbyte;

endmodule

// [verilog/twd_host.sv]
/*
 Host end of the two-wire debug port: makes the link clock by a divider
 and shifts frames. Assumes software on the register port, same clock.
*/
`timescale 1ns/100ps
`include "twd_defines.svh"
module twd_host
   import twd_pkg::*;
#(
   parameter int HALF = `TWD_HALF_PERIOD
)(
   input  wire logic       mclk_in,
   input  wire logic       resetn_in,
   twd_link_if.host        link,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [7:0]      rdata_out
);

   if (HALF < `TWD_HALF_MIN || HALF > 256)
   begin
      $error("HALF out of range");
   end

   localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

////////////////////////////////////////////////////////////////////////////////

   twd_host_t q;
   twd_host_t d;

   always_comb
   begin
      logic dt_new;
      logic tick;
      dt_new = 1'b0;
      tick   = 1'b0;
      d = q;
      d.dt_sync = {q.dt_sync[1:0], link.debug_link_data_pin};
      dt_new = (q.dt_sync[1] == q.dt_sync[2]) ? q.dt_sync[2] : q.dt_st;
      d.dt_st = dt_new;
      tick = (q.div == HALF_LAST);
      d.div = tick ? 8'h00 : q.div + 8'h01;
      // Register port; busy refuses a new command
      d.rdata = 8'h00;
      if (wr_in && addr_in == `TWD_HREG_DATA)
      begin
         d.tx = wdata_in;
      end
      else if (wr_in && addr_in == `TWD_HREG_COMMAND && !q.busy)
      begin
         d.busy  = 1'b1;
         d.rd    = (wdata_in[1:0] == `TWD_INS_DATA_READ) ||
                   (wdata_in[1:0] == `TWD_INS_ADDR_READ);
         d.frame = {1'b1, wdata_in[1:0], q.tx};
         d.st    = HS_LOW;
         d.clk   = 1'b0;
         d.oe    = 1'b1;
         d.dout  = 1'b1;
         d.bitn  = 4'h0;
         d.div   = 8'h00;
      end
      if (rd_in)
      begin
         if (addr_in == `TWD_HREG_DATA)
         begin
            d.rdata    = q.rxdata;
            d.rx_valid = 1'b0;
         end
         else if (addr_in == `TWD_HREG_STATUS)
         begin
            d.rdata = {6'h00, q.busy, q.rx_valid};
         end
      end
      case (q.st)
         HS_IDLE:
         begin
            d.clk = (d.st == HS_LOW) ? 1'b0 : 1'b1;
         end
         HS_LOW:
         begin
            if (tick)
            begin
               d.clk = 1'b1;
               d.st  = HS_HIGH;
               // Sample late in the low phase: target drives after its fall
               if (q.rd && q.bitn >= `TWD_FIRST_DATA_BIT)
               begin
                  d.rx = {q.rx[6:0], dt_new};
               end
            end
         end
         HS_HIGH:
         begin
            if (tick)
            begin
               d.clk  = 1'b0;
               d.bitn = q.bitn + 4'h1;
               if (q.bitn == `TWD_LAST_BIT)
               begin
                  d.oe = 1'b0;
                  d.st = HS_TAIL;
               end
               else
               begin
                  d.st    = HS_LOW;
                  d.frame = {q.frame[9:0], 1'b0};
                  d.dout  = q.frame[9];
                  d.oe    = !(q.rd && q.bitn + 4'h1 >= `TWD_FIRST_DATA_BIT);
               end
            end
         end
         HS_TAIL:
         begin
            if (tick)
            begin
               d.clk = 1'b1;
               d.st  = HS_GAP;
               if (q.rd)
               begin
                  d.rxdata   = q.rx;
                  d.rx_valid = 1'b1;
               end
            end
         end
         HS_GAP:
         begin
            if (tick)
            begin
               d.st   = HS_IDLE;
               d.busy = 1'b0;
               d.oe   = 1'b1;
               d.dout = 1'b0;
            end
         end
         default:
         begin
            d.st = HS_IDLE;
         end
      endcase
   end

////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         q      <= '0;
         q.clk  <= 1'b1;
         q.oe   <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign link.debug_link_clock_pin = q.clk;
   assign link.host_data_out        = q.dout;
   assign link.host_data_oe         = q.oe;
   assign rdata_out                 = q.rdata;

endmodule

// [bench/twd_props.sv]
/*
 Link checker of the two-wire debug port: watches both ends' drivers.
 Assumes HALF equals the host instance's half period.
*/
`timescale 1ns/100ps
module twd_props
#(
   parameter int HALF = 16
)(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic debug_link_clock_pin,
   input wire logic host_data_out,
   input wire logic host_data_oe,
   input wire logic dev_data_out,
   input wire logic dev_data_oe,
   input wire logic debug_link_data_pin
);
   // Target answer spans eight link periods; sync latency cancels out
   localparam int RD_LO = 16 * HALF - 4;
   localparam int RD_HI = 16 * HALF + 4;
   localparam int TL_LO = HALF - 2;
   localparam int TL_HI = HALF + 2;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////////////////////
   sequence host_release_s;
      $fell(host_data_oe) && !debug_link_clock_pin;
   endsequence
   sequence dev_take_s;
      $rose(dev_data_oe);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_single_driver: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive the data pin");
   a_clk_low_hold: assert property (
      $fell(debug_link_clock_pin) |-> !debug_link_clock_pin[*8])
      else $error("link clock low phase too short");
   a_clk_high_hold: assert property (
      $rose(debug_link_clock_pin) |-> debug_link_clock_pin[*8])
      else $error("link clock high phase too short");
   a_host_data_edge: assert property (
      $changed(host_data_out) && host_data_oe && $past(host_data_oe) |-> !debug_link_clock_pin)
      else $error("host data changed while clock high");
   a_dev_data_edge: assert property (
      $changed(dev_data_out) && dev_data_oe && $past(dev_data_oe) |-> !debug_link_clock_pin)
      else $error("target data changed while clock high");
   a_dev_take_low: assert property (dev_take_s |-> !debug_link_clock_pin && !host_data_oe)
      else $error("target took the pin at a bad moment");
   a_dev_hold_byte: assert property (dev_take_s |-> dev_data_oe[*8])
      else $error("target released too early");
   a_dev_release_span: assert property (
      dev_take_s |-> ##[RD_LO:RD_HI] $fell(dev_data_oe))
      else $error("target answer not eight bits long");
   a_host_tail_rise: assert property (
      host_release_s |-> ##[TL_LO:TL_HI] $rose(debug_link_clock_pin))
      else $error("no clock rise after host release");
   a_host_tail_quiet: assert property (host_release_s |-> !host_data_oe[*8])
      else $error("host drove again inside the tail");
endmodule

// [bench/two_wire_debug_flash_regs_bench.sv]
/*
 Bench of the two-wire debug port: host and target joined by the link.
 Assumes design files and the defines header are compiled beforehand.
*/
`timescale 1ns/100ps
`include "twd_defines.svh"
module two_wire_debug_flash_regs_bench;
   import twd_pkg::*;
   localparam int         HALF   = 12;
   localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary identity value
   localparam logic [7:0] REV_ID = 8'h07;
   logic       mclk_in   = 1'b0;
   logic       resetn_in = 1'b0;
   logic [3:0] addr_in   = 4'h0;
   logic [7:0] wdata_in  = 8'h00;
   logic       wr_in     = 1'b0;
   logic       rd_in     = 1'b0;
   logic       halted_in = 1'b1;
   logic       load_in   = 1'b0;
   logic [7:0] load_data = 8'h00;
   logic       done_in   = 1'b0;
   logic [7:0] rdata_out, cmd, fbyte, last_cmd, last_byte, got;
   logic       prog, urst_n, udata, cmd_v, blk, era, byte_v;
   int         errors = 0;
   int         comparisons = 0;
   int         n_cmd = 0, n_blk = 0, n_era = 0, n_byte = 0;
   int         n_rst_lo = 0, n_ud_hi = 0;

   always #12.5 mclk_in = ~mclk_in;

   twd_link_if link ();
   twd_host #(.HALF(HALF)) u_twd_host (.mclk_in(mclk_in), .resetn_in(resetn_in), .link(link),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
   twd_target #(.DEVICE_ID(DEV_ID), .REVISION_ID(REV_ID)) u_twd_target (.mclk_in(mclk_in),
      .resetn_in(resetn_in), .link(link), .halted_in(halted_in), .flash_load_in(load_in),
      .flash_load_data_in(load_data), .flash_done_in(done_in), .prog_enabled_out(prog),
      .user_rst_n_out(urst_n), .user_data_out(udata), .flash_cmd_valid_out(cmd_v),
      .flash_cmd_out(cmd), .flash_block_read_out(blk), .flash_device_erase_out(era),
      .flash_byte_valid_out(byte_v), .flash_byte_out(fbyte));
   twd_props #(.HALF(HALF)) u_twd_props (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .debug_link_clock_pin(link.debug_link_clock_pin), .host_data_out(link.host_data_out),
      .host_data_oe(link.host_data_oe), .dev_data_out(link.dev_data_out),
      .dev_data_oe(link.dev_data_oe), .debug_link_data_pin(link.debug_link_data_pin));
   ////////////////////////////////////////////////////////////////////////////////
   // Pulses last one cycle, so count them here rather than poll
   always @(posedge mclk_in)
   begin
      if (cmd_v === 1'b1)
         last_cmd = cmd;
      if (byte_v === 1'b1)
         last_byte = fbyte;
      n_cmd += (cmd_v === 1'b1);
      n_blk += (blk === 1'b1);
      n_era += (era === 1'b1);
      n_byte += (byte_v === 1'b1);
      n_rst_lo += (urst_n === 1'b0);
      n_ud_hi += (udata === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         $display("[ERR] %0t byte %h expected %h", $time, g, e);
         errors++;
      end
   endtask

   task automatic check_bit(input logic g, input logic e);
      comparisons++;
      if (g !== e)
      begin
         $display("[ERR] %0t flag %b expected %b", $time, g, e);
         errors++;
      end
   endtask

   task automatic check_count(input int g, input int e);
      comparisons++;
      if (g != e)
      begin
         $display("[ERR] %0t count %0d expected %0d", $time, g, e);
         errors++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Extra edge after each strobe keeps one assignment per time step
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
      @(posedge mclk_in);
   endtask

   task automatic frame(input logic [1:0] ins, input logic [7:0] d);
      logic [7:0] s;
      int         k;
      reg_wr(`TWD_HREG_DATA, d);
      reg_wr(`TWD_HREG_COMMAND, {6'h00, ins});
      for (k = 0; k < 400; k++)
      begin
         reg_rd(`TWD_HREG_STATUS, s);
         if (s[1] === 1'b0)
            break;
      end
      if (k == 400)
      begin
         $display("[ERR] %0t frame timeout", $time);
         errors++;
         report_and_stop();
      end
   endtask

   task automatic link_rd(input logic [7:0] sel, output logic [7:0] d);
      frame(`TWD_INS_ADDR_WRITE, sel);
      frame(`TWD_INS_DATA_READ, 8'h00);
      reg_rd(`TWD_HREG_DATA, d);
   endtask

   task automatic link_wr(input logic [7:0] sel, input logic [7:0] d);
      frame(`TWD_INS_ADDR_WRITE, sel);
      frame(`TWD_INS_DATA_WRITE, d);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      link_rd(`TWD_SEL_FLASH_PROG_CONTROL, got);
      check_byte(got, `TWD_PROG_CTL_RESET);
      link_rd(`TWD_SEL_FLASH_PROG_DATA, got);
      check_byte(got, `TWD_PROG_DAT_RESET);
      frame(`TWD_INS_ADDR_READ, 8'h00);
      reg_rd(`TWD_HREG_DATA, got);
      check_byte(got, `TWD_SEL_FLASH_PROG_DATA);
      link_rd(8'h55, got);
      check_byte(got, `TWD_UNMAPPED_READ);
   endtask

   task automatic t_ident;
      link_wr(`TWD_SEL_DEVICE_IDENTITY, 8'hff);
      link_rd(`TWD_SEL_DEVICE_IDENTITY, got);
      check_byte(got, DEV_ID);
      link_wr(`TWD_SEL_SILICON_REVISION, 8'hff);
      link_rd(`TWD_SEL_SILICON_REVISION, got);
      check_byte(got, REV_ID);
   endtask

   task automatic t_unlock;
      link_wr(`TWD_SEL_FLASH_PROG_DATA, `TWD_CMD_BLOCK_READ);
      check_count(n_cmd, 0);
      link_wr(`TWD_SEL_FLASH_PROG_CONTROL, `TWD_UNLOCK_SECOND);
      link_wr(`TWD_SEL_FLASH_PROG_CONTROL, `TWD_UNLOCK_FIRST);
      check_bit(prog, 1'b0);
      link_wr(`TWD_SEL_FLASH_PROG_CONTROL, `TWD_UNLOCK_SECOND);
      check_bit(prog, 1'b1);
      link_rd(`TWD_SEL_FLASH_PROG_CONTROL, got);
      check_byte(got, `TWD_UNLOCK_SECOND);
   endtask

   task automatic t_cmds;
      link_wr(`TWD_SEL_FLASH_PROG_DATA, `TWD_CMD_BLOCK_READ);
      check_count(n_blk, 1);
      check_byte(last_cmd, `TWD_CMD_BLOCK_READ);
      link_wr(`TWD_SEL_FLASH_PROG_DATA, 8'h5e);
      check_count(n_byte, 1);
      check_byte(last_byte, 8'h5e);
      done_in <= 1'b1;
      @(posedge mclk_in);
      done_in <= 1'b0;
      link_wr(`TWD_SEL_FLASH_PROG_DATA, `TWD_CMD_DEVICE_ERASE);
      check_count(n_era, 1);
      check_byte(last_cmd, `TWD_CMD_DEVICE_ERASE);
      check_count(n_cmd, 2);
      load_data <= 8'h77;
      load_in <= 1'b1;
      @(posedge mclk_in);
      load_in <= 1'b0;
      link_rd(`TWD_SEL_FLASH_PROG_DATA, got);
      check_byte(got, 8'h77);
      link_wr(`TWD_SEL_FLASH_PROG_CONTROL, 8'h00);
      check_bit(prog, 1'b1);
   endtask

   // Running core ignores the link; the pull-up answers instead
   task automatic t_running;
      int rl;
      int uh;
      halted_in <= 1'b0;
      rl = n_rst_lo;
      uh = n_ud_hi;
      link_rd(`TWD_SEL_DEVICE_IDENTITY, got);
      check_byte(got, 8'hff);
      check_bit(urst_n, 1'b1);
      check_bit(udata, 1'b0);
      check_bit(n_rst_lo > rl && n_ud_hi > uh, 1'b1);
      halted_in <= 1'b1;
      @(posedge mclk_in);
      // Halted frame toggles both pins; user side must not see it
      rl = n_rst_lo;
      uh = n_ud_hi;
      link_rd(`TWD_SEL_DEVICE_IDENTITY, got);
      check_byte(got, DEV_ID);
      check_count(n_rst_lo - rl, 0);
      check_count(n_ud_hi - uh, 0);
   endtask

   task automatic t_reset;
      resetn_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      check_bit(prog, 1'b0);
      link_rd(`TWD_SEL_FLASH_PROG_CONTROL, got);
      check_byte(got, `TWD_PROG_CTL_RESET);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      t_regs();
      t_ident();
      t_unlock();
      t_cmds();
      t_running();
      t_reset();
      report_and_stop();
   end
endmodule
